// file: logic/nvbm_consts.vh
`ifndef NVBM_CONSTS_VH
`define NVBM_CONSTS_VH
// Array geometry
`define NVBM_ADDR_W 13
`define NVBM_DEPTH 8192
// Slave address layout: type code in 7..4, select in 3..1, direction in 0
`define NVBM_TYPE_HI 7
`define NVBM_TYPE_LO 4
`define NVBM_SEL_HI 3
`define NVBM_SEL_LO 1
`define NVBM_RW_BIT 0
// Device-type code, value arbitrary
`define NVBM_TYPE_CODE 4'h5
// Bits in a byte before the acknowledge slot
`define NVBM_BITS 4'h8
`endif

// file: logic/nvbm_array.v
`timescale 1ns/1ps
`default_nettype none
// Byte-wide storage, one write port, asynchronous read by index
module nvbm_array #(
  parameter AW = 13,
  parameter DEPTH = 8192
) (
  input wire clock_i,
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [7:0] wr_data_i,
  input wire [AW-1:0] rd_addr_i,
  output wire [7:0] rd_data_o
);
  reg [7:0] mem_reg [0:DEPTH-1];

  // Contents survive reset, as a nonvolatile array would
  always @(posedge clock_i) begin
    if (wr_en_i) begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  assign rd_data_o = mem_reg[rd_addr_i];
endmodule
`default_nettype wire

// file: logic/nvbm_i2c_slave.v
// Functional notes
// - Answer only when received select bits equal the select pins; eight parts share bus.
// - Floating select pins read as zero.
// - Sample SDA on SCL rise; change driven SDA on SCL fall.
// - SDA is only pulled low or released, never driven high.
// - Write-protect high blocks all array writes; low or floating allows them.
// - Array of 8K bytes, shifted serially one bit per clock.
// - Two address bytes follow slave address; low 13 bits used, top 3 ignored.
// - Each data byte is committed as soon as its eighth bit arrives.
// - No busy state; new transactions are acknowledged at once.
// - Slave byte: type code 7..4, select 3..1, direction bit 0 (one reads).
// - Address increments after each data byte, before acknowledge; wraps to zero.
// - Read sends eight bits, continues on acknowledge, ends on no-acknowledge.
// - Write after eighth bit; START or STOP earlier leaves memory unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "nvbm_consts.vh"
module nvbm_i2c_slave #(
  parameter AW = `NVBM_ADDR_W,
  parameter DEPTH = `NVBM_DEPTH
) (
  input wire clock_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  input wire [2:0] device_select_pins_i,
  input wire write_protect_i
);
  // Phases of a transaction
  localparam ST_IDLE = 3'h0;
  localparam ST_SLAVE = 3'h1;
  localparam ST_ADDR_HI = 3'h2;
  localparam ST_ADDR_LO = 3'h3;
  localparam ST_WDATA = 3'h4;
  localparam ST_RDATA = 3'h5;
  localparam ST_RACK = 3'h6;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  reg [1:0] scl_sync_reg;
  reg [1:0] sda_sync_reg;
  reg [2:0] sel_a_reg;
  reg [2:0] sel_b_reg;
  reg wp_a_reg;
  reg wp_b_reg;
  reg scl_d_reg;
  reg sda_d_reg;

  // Two stages on every pin; the first stage feeds only the second
  always @(posedge clock_i) begin
    if (rst_i) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      sel_a_reg <= 3'h0;
      sel_b_reg <= 3'h0;
      wp_a_reg <= 1'b0;
      wp_b_reg <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      sel_a_reg <= device_select_pins_i;
      sel_b_reg <= sel_a_reg;
      wp_a_reg <= write_protect_i;
      wp_b_reg <= wp_a_reg;
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end

  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  // Edge of SDA while SCL holds high marks START or STOP
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  ////////////////////////////////////////////////////////////////////////
  // Protocol state
  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [AW-1:0] addr_reg;
  reg ack_slot_reg;
  reg sda_low_reg;
  reg nack_reg;
  reg wr_en_reg;
  reg [7:0] wr_data_reg;
  reg [AW-1:0] wr_addr_reg;
  wire [7:0] rd_data;

  // Byte just completed with the current rising-edge bit
  wire [7:0] byte_in = {shift_reg[6:0], sda_s};
  // Floating pins are pulled down outside; the synchronised pins in sel_b_reg are the match reference
  wire sel_match = (byte_in[`NVBM_SEL_HI:`NVBM_SEL_LO] == sel_b_reg);
  wire type_match = (byte_in[`NVBM_TYPE_HI:`NVBM_TYPE_LO] == `NVBM_TYPE_CODE);

  // Wrapping increment, used for reads and writes alike
  function [AW-1:0] next_addr;
    input [AW-1:0] a;
    begin
      next_addr = a + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  always @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      addr_reg <= {AW{1'b0}};
      ack_slot_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      nack_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      wr_data_reg <= 8'h00;
      wr_addr_reg <= {AW{1'b0}};
    end else begin
      wr_en_reg <= 1'b0;
      if (start_det) begin
        // Abort anything in flight; partial byte never reaches the array
        state_reg <= ST_SLAVE;
        bit_cnt_reg <= 4'h0;
        ack_slot_reg <= 1'b0;
        sda_low_reg <= 1'b0;
      end else if (stop_det) begin
        state_reg <= ST_IDLE;
        bit_cnt_reg <= 4'h0;
        ack_slot_reg <= 1'b0;
        sda_low_reg <= 1'b0;
      end else if (state_reg != ST_IDLE) begin
        if (scl_rise) begin
          // Sample on rising edge only
          if (ack_slot_reg) begin
            nack_reg <= sda_s; // Master answer after a read byte
          end else begin
            shift_reg <= byte_in;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == (`NVBM_BITS - 4'h1)) begin
              case (state_reg)
                ST_SLAVE: begin
                  if (!(type_match && sel_match)) begin
                    state_reg <= ST_IDLE; // Not ours: stay off the bus
                  end else if (byte_in[`NVBM_RW_BIT]) begin
                    // Read: hold here so this byte is still acked; fall enters ST_RDATA
                    state_reg <= ST_SLAVE;
                  end else begin
                    state_reg <= ST_ADDR_HI;
                  end
                end
                ST_ADDR_HI: begin
                  addr_reg[AW-1:8] <= byte_in[AW-9:0]; // Top 3 bits dropped
                  state_reg <= ST_ADDR_LO;
                end
                ST_ADDR_LO: begin
                  addr_reg[7:0] <= byte_in;
                  state_reg <= ST_WDATA;
                end
                ST_WDATA: begin
                  // Commit at once, well before the ack slot ends
                  wr_en_reg <= ~wp_b_reg;
                  wr_data_reg <= byte_in;
                  wr_addr_reg <= addr_reg;
                  addr_reg <= next_addr(addr_reg);
                end
                ST_RDATA: begin
                  addr_reg <= next_addr(addr_reg);
                end
                default: begin
                  state_reg <= ST_IDLE;
                end
              endcase
            end
          end
        end else if (scl_fall) begin
          // Drive changes only on falling edge
          if (bit_cnt_reg == `NVBM_BITS && !ack_slot_reg) begin
            ack_slot_reg <= 1'b1;
            bit_cnt_reg <= 4'h0;
            // Slave acks what it receives; on reads the master acks
            sda_low_reg <= (state_reg != ST_RDATA);
            if (state_reg == ST_RDATA) begin
              state_reg <= ST_RACK;
            end
            if (state_reg == ST_SLAVE && shift_reg[`NVBM_RW_BIT]) begin
              state_reg <= ST_RDATA;
            end
          end else if (ack_slot_reg) begin
            ack_slot_reg <= 1'b0;
            if (state_reg == ST_RACK) begin
              if (nack_reg) begin
                state_reg <= ST_IDLE; // No-ack ends the read
                sda_low_reg <= 1'b0;
              end else begin
                state_reg <= ST_RDATA;
                sda_low_reg <= ~rd_data[7];
              end
            end else if (state_reg == ST_RDATA) begin
              sda_low_reg <= ~rd_data[7]; // First read bit
            end else begin
              sda_low_reg <= 1'b0;
            end
          end else if (state_reg == ST_RDATA) begin
            // Bits 6..0 out MSB first
            sda_low_reg <= ~rd_data[3'h7 - bit_cnt_reg[2:0]];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Open-drain pin: output level is always low, only the enable moves
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_low_reg;

  nvbm_array #(
    .AW(AW),
    .DEPTH(DEPTH)
  ) u_array (
    .clock_i(clock_i),
    .wr_en_i(wr_en_reg),
    .wr_addr_i(wr_addr_reg),
    .wr_data_i(wr_data_reg),
    .rd_addr_i(addr_reg),
    .rd_data_o(rd_data)
  );
endmodule
`default_nettype wire

// file: verification/nvbm_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the slave's pins only
module nvbm_asserts (
  input wire clock_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire [2:0] device_select_pins_i,
  input wire write_protect_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Open drain, and it moves only while SCL is low
  a_never_high: assert property (sda_o == 1'b0) else $error("sda high");
  a_moves_low: assert property ($changed(sda_oe_o) |-> !$past(scl_i)) else $error("oe moved");
  a_steady_high: assert property ($rose(scl_i) |=> $stable(sda_oe_o) [*6])
    else $error("oe unsteady");
  a_drive_stands: assert property ($rose(sda_oe_o) |-> sda_oe_o [*5]) else $error("oe short");
  a_drive_ends: assert property (sda_oe_o |-> ##[1:200] !sda_oe_o) else $error("oe stuck");
  // START and STOP leave the line free
  a_start_frees: assert property (scl_i && $past(scl_i) && $fell(sda_i) |-> ##4 !sda_oe_o)
    else $error("oe after start");
  a_stop_frees: assert property (scl_i && $past(scl_i) && $rose(sda_i) |-> !sda_oe_o [*4])
    else $error("oe after stop");
  a_reset_quiet: assert property ($fell(rst_i) |-> !sda_oe_o [*4]) else $error("oe early");
  // Main traffic seen
  c_drive: cover property ($rose(sda_oe_o));
  c_start: cover property (scl_i && $fell(sda_i));
  c_wp: cover property (write_protect_i && $rose(sda_oe_o));
endmodule
bind nvbm_i2c_slave nvbm_asserts u_chk (.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .device_select_pins_i(device_select_pins_i), .write_protect_i(write_protect_i));
`default_nettype wire

// file: verification/nvbm_master.sv
`timescale 1ns/1ps
`default_nettype none
// Bus master: drives SCL, releases or pulls SDA
module nvbm_master (
  input wire clock_i,
  input wire sda_i,
  output logic scl_o,
  output logic sda_rel_o
);
  integer q = 2;
  // Idle bus: SCL stands high outside frames
  initial begin
    scl_o = 1'b1;
    sda_rel_o = 1'b1;
  end
  // Quarter bit time; q of 2 gives 320 ns a bit
  task w(input integer n);
    repeat (n * q) @(negedge clock_i);
  endtask
  // SDA falls with SCL high, also as a repeated start
  task start;
    sda_rel_o = 1'b1;
    w(1);
    scl_o = 1'b1;
    w(2);
    sda_rel_o = 1'b0;
    w(2);
    scl_o = 1'b0;
    w(1);
  endtask
  task stop;
    sda_rel_o = 1'b0;
    w(1);
    scl_o = 1'b1;
    w(2);
    sda_rel_o = 1'b1;
    w(2);
  endtask
  // Data set while SCL low, sampled at the end of SCL high
  task bit_io(input b, output r);
    sda_rel_o = b;
    w(1);
    scl_o = 1'b1;
    w(2);
    r = sda_i;
    scl_o = 1'b0;
    w(1);
  endtask
  task send(input [7:0] d, output ack);
    integer i;
    reg r;
    for (i = 7; i >= 0; i = i - 1)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // Acknowledge asks for more, no-acknowledge ends the read
  task recv(input more, output [7:0] d);
    integer i;
    reg r;
    for (i = 7; i >= 0; i = i - 1)
      bit_io(1'b1, d[i]);
    bit_io(~more, r);
  endtask
endmodule
`default_nettype wire

// file: verification/i2c_serial_nv_byte_memory_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "nvbm_consts.vh"
module i2c_serial_nv_byte_memory_tb_top;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] pins = 3'h0;
  logic wp = 1'b0;
  logic ack;
  logic [7:0] d;
  integer n_mismatch = 0;
  integer checked = 0;
  integer p;
  wire scl, rel, sda_o, oe;
  // Pull-up wire, AND of both parties
  wire sda = (oe ? sda_o : 1'b1) & rel;
  always #20 clock_i = ~clock_i;
  nvbm_i2c_slave u_dut (.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(oe), .device_select_pins_i(pins), .write_protect_i(wp));
  nvbm_master u_mst (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_rel_o(rel));
  ////////////////////////////////////////////////////////////////////////////////
  task test_done;
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk_byte(input string what, input [7:0] exp, input [7:0] got);
    checked = checked + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task chk_ack(input string what, input exp, input got);
    chk_byte(what, {7'h00, exp}, {7'h00, got});
  endtask
  // Write header: slave byte then two address bytes
  task open_at(input [15:0] a);
    u_mst.start;
    u_mst.send({`NVBM_TYPE_CODE, pins, 1'b0}, ack);
    u_mst.send(a[15:8], ack);
    u_mst.send(a[7:0], ack);
    chk_ack("addr ack", 1'b1, ack);
  endtask
  task rd_open;
    u_mst.start;
    u_mst.send({`NVBM_TYPE_CODE, pins, 1'b1}, ack);
    chk_ack("read ack", 1'b1, ack);
  endtask
  // Burst over the top of the array, top address bits set
  task s_wrap;
    open_at(16'hFFFF);
    u_mst.send(8'hAA, ack);
    u_mst.send(8'h55, ack);
    u_mst.stop;
    open_at(16'h3FFF);
    rd_open;
    u_mst.recv(1'b1, d);
    chk_byte("last", 8'hAA, d);
    u_mst.recv(1'b0, d);
    chk_byte("wrapped", 8'h55, d);
    u_mst.stop;
  endtask
  // Every select value; wrong select or type code is ignored
  task s_select;
    for (p = 0; p < 8; p = p + 1) begin
      pins = p[2:0];
      u_mst.start;
      u_mst.send({`NVBM_TYPE_CODE, pins ^ 3'h1, 1'b0}, ack);
      chk_ack("other sel", 1'b0, ack);
      u_mst.start;
      u_mst.send({`NVBM_TYPE_CODE ^ 4'h3, pins, 1'b0}, ack);
      chk_ack("other type", 1'b0, ack);
      u_mst.start;
      u_mst.send({`NVBM_TYPE_CODE, pins, 1'b0}, ack);
      chk_ack("own sel", 1'b1, ack);
      u_mst.stop;
    end
    pins = 3'h0;
  endtask
  // Protected write acked and address advanced; the kept byte at 0x0005 is read back in s_abort
  task s_protect;
    open_at(16'h0005);
    u_mst.send(8'h11, ack);
    u_mst.send(8'h22, ack);
    u_mst.stop;
    wp = 1'b1;
    open_at(16'h0005);
    u_mst.send(8'h99, ack);
    chk_ack("wp ack", 1'b1, ack);
    u_mst.stop;
    wp = 1'b0;
    rd_open;
    u_mst.recv(1'b0, d);
    chk_byte("wp next", 8'h22, d);
    u_mst.stop;
  endtask
  // STOP inside the seventh bit (its SCL pulse is the seventh), then a slow read back
  task s_abort;
    integer i;
    open_at(16'h0005);
    for (i = 0; i < 6; i = i + 1)
      u_mst.bit_io(1'b0, ack);
    u_mst.stop;
    u_mst.q = 4;
    open_at(16'h0005);
    rd_open;
    u_mst.recv(1'b0, d);
    chk_byte("kept", 8'h11, d);
    u_mst.stop;
    u_mst.q = 2;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(negedge clock_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clock_i);
    s_wrap;
    s_select;
    s_protect;
    s_abort;
    test_done;
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clock_i);
    n_mismatch = n_mismatch + 1;
    test_done;
  end
endmodule
`default_nettype wire
